// ===== rtl/ptsf_edge.sv
// ptsf_edge: one-cycle pulse on a chosen edge of a level.
// assumes the level is synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module ptsf_edge #(
    parameter bit RISE = 1'b1
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level in, pulse out
    input  wire logic level_i,
    output logic      pulse_o
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level_i;
    end

    // previous level resets to the idle value so no edge is seen at release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_q <= ~RISE;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign pulse_o = RISE ? (level_i & ~prev_q) : (~level_i & prev_q);
endmodule
`default_nettype wire

// ===== rtl/ptsf_pkg.sv
// ptsf_pkg: offsets, field positions, reset values and bus carriers of the
// target-side status flags block.
// assumes a 16-bit byte address and 32-bit data on the register port.
package ptsf_pkg;

    // register byte addresses
    localparam logic [15:0] STATUS_OFS = 16'hd094;
    localparam logic [15:0] MASK_OFS   = 16'hd098;

    // field positions in the status and mask words
    localparam int PSC_BIT  = 24;
    localparam int WES_BIT  = 23;
    localparam int WSC_BIT  = 22;
    localparam int M66_BIT  = 21;
    localparam int IOBE_BIT = 20;
    localparam int IIBE_BIT = 19;
    localparam int TOBE_BIT = 18;
    localparam int TIBE_BIT = 17;

    // values after reset
    localparam logic [2:0]  FLAGS_RST = 3'h0;
    localparam logic [3:0]  EMPTY_RST = 4'hf;
    localparam logic [3:0]  MASK_RST  = 4'h0;
    localparam logic [31:0] RDATA_RST = 32'h0;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ptsf_bus_req_s;

    // fifo empty indicators, bit 3 initiator outbound down to bit 0 target inbound
    typedef struct packed {
        logic init_out;
        logic init_in;
        logic tgt_out;
        logic tgt_in;
    } ptsf_empty_s;

endpackage

// ===== rtl/ptsf_top.sv
// ptsf_top: target-side status register with power-management event flags,
// 66 MHz enable status, fifo empty indicators, mask and interrupt.
// assumes config-space events and pin levels are synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module ptsf_top (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // register port
    input  wire ptsf_pkg::ptsf_bus_req_s bus_i,
    output logic [31:0]                 rdata_o,
    // power-management config space view
    input  wire logic                   pstate_wr_i,
    input  wire logic                   wake_en_i,
    input  wire logic                   wake_status_i,
    // mode and pins
    input  wire logic                   host_mode_i,
    input  wire logic                   m66en_i,
    input  wire ptsf_pkg::ptsf_empty_s  empty_i,
    // interrupt
    output logic                        irq_o
);
    logic       wake_en_rise;
    logic       wake_st_fall;
    logic [2:0] set_ev;
    logic [2:0] clr_ev;
    logic [2:0] flags;
    logic       st_wr;
    logic       mk_wr;

    // satellite mode only: in host mode no event is recorded
    assign set_ev[2] = pstate_wr_i & ~host_mode_i;
    assign set_ev[1] = wake_en_rise & ~host_mode_i;
    assign set_ev[0] = wake_st_fall & ~host_mode_i;

    assign st_wr = bus_i.wr & (bus_i.addr == ptsf_pkg::STATUS_OFS);
    assign mk_wr = bus_i.wr & (bus_i.addr == ptsf_pkg::MASK_OFS);

    // write-one-to-clear strobes
    assign clr_ev[2] = st_wr & bus_i.wdata[ptsf_pkg::PSC_BIT];
    assign clr_ev[1] = st_wr & bus_i.wdata[ptsf_pkg::WES_BIT];
    assign clr_ev[0] = st_wr & bus_i.wdata[ptsf_pkg::WSC_BIT];

    ptsf_edge #(
        .RISE (1'b1)
    ) u_wake_en_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (wake_en_i),
        .pulse_o (wake_en_rise)
    );

    ptsf_edge #(
        .RISE (1'b0)
    ) u_wake_st_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (wake_status_i),
        .pulse_o (wake_st_fall)
    );

    for (genvar g = 0; g < 3; g++) begin : g_flag
        ptsf_w1c_flag u_flag (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .set_i  (set_ev[g]),
            .clr_i  (clr_ev[g]),
            .flag_o (flags[g])
        );
    end

    // live pin samples
    logic       m66_q;
    logic       m66_d;
    logic [3:0] empty_q;
    logic [3:0] empty_d;

    always_comb begin
        m66_d   = m66en_i;
        empty_d = empty_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            m66_q   <= 1'b0;
            empty_q <= ptsf_pkg::EMPTY_RST;
        end else begin
            m66_q   <= m66_d;
            empty_q <= empty_d;
        end
    end

    // mask register, bits 24 to 21
    logic [3:0] mask_q;
    logic [3:0] mask_d;

    always_comb begin
        mask_d = mask_q;
        if (mk_wr) begin
            mask_d = bus_i.wdata[ptsf_pkg::PSC_BIT:ptsf_pkg::M66_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= ptsf_pkg::MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // status word assembly; everything else is zero
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0;
        status_word[ptsf_pkg::PSC_BIT]  = flags[2];
        status_word[ptsf_pkg::WES_BIT]  = flags[1];
        status_word[ptsf_pkg::WSC_BIT]  = flags[0];
        status_word[ptsf_pkg::M66_BIT]  = m66_q;
        status_word[ptsf_pkg::IOBE_BIT] = empty_q[3];
        status_word[ptsf_pkg::IIBE_BIT] = empty_q[2];
        status_word[ptsf_pkg::TOBE_BIT] = empty_q[1];
        status_word[ptsf_pkg::TIBE_BIT] = empty_q[0];
    end

    // read data stands one cycle after the strobe, zero otherwise
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                ptsf_pkg::STATUS_OFS: begin
                    rdata_d = status_word;
                end
                ptsf_pkg::MASK_OFS: begin
                    rdata_d = 32'h0;
                    rdata_d[ptsf_pkg::PSC_BIT:ptsf_pkg::M66_BIT] = mask_q;
                end
                default: begin
                    rdata_d = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= ptsf_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // interrupt level; the 66 MHz source cannot be cleared, only masked,
    // and is never signalled in host mode
    logic irq_q;
    logic irq_d;

    always_comb begin
        irq_d = |(flags & mask_q[3:1])
              | (m66_q & mask_q[0] & ~host_mode_i);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;
endmodule
`default_nettype wire

// ===== rtl/ptsf_w1c_flag.sv
// ptsf_w1c_flag: sticky flag set by hardware, cleared by software writing one.
// assumes set and clear are one-cycle pulses on clk_i.
`timescale 1ns/100ps
`default_nettype none
module ptsf_w1c_flag (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // set and clear
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clr_i) begin
            flag_d = 1'b0;
        end
        // an event in the clearing cycle is kept
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule
`default_nettype wire

// ===== sim/ptsf_host_model.sv
// ptsf_host_model: host writing the power-management control/status register.
// assumes the caller sits just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module ptsf_host_model (
    // clock
    input wire logic clk_i,
    // config space view
    output logic     pstate_wr_o,
    output logic     wake_en_o,
    output logic     wake_status_o
);
    initial begin
        pstate_wr_o = 1'b0;
        wake_en_o = 1'b0;
        wake_status_o = 1'b1;
    end
    // kind 1 state rewrite, 2 wake enable set, 3 wake status clear
    task automatic pm_write(input logic [1:0] kind);
        @(posedge clk_i);
        case (kind)
            2'h1: pstate_wr_o <= 1'b1;
            2'h2: wake_en_o <= 1'b1;
            2'h3: wake_status_o <= 1'b0;
            default: ;
        endcase
        @(posedge clk_i);
        pstate_wr_o <= 1'b0;
        wake_en_o <= 1'b0;
        wake_status_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== sim/ptsf_top_monitor.sv
// ptsf_top_monitor: port assertions for ptsf_top.
// assumes one clock domain, async active-high reset.
`timescale 1ns/100ps
`default_nettype none
module ptsf_top_monitor (
    // clock, reset, bus
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire ptsf_pkg::ptsf_bus_req_s bus_i,
    input wire logic [31:0]             rdata_o,
    // events, pins, irq
    input wire logic                    pstate_wr_i,
    input wire logic                    wake_en_i,
    input wire logic                    wake_status_i,
    input wire logic                    host_mode_i,
    input wire logic                    m66en_i,
    input wire ptsf_pkg::ptsf_empty_s   empty_i,
    input wire logic                    irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_st;
    assign rd_st = bus_i.rd && bus_i.addr == ptsf_pkg::STATUS_OFS;
    // one idle cycle with no write between event and read, as the host model paces it
    sequence psc_s; pstate_wr_i && !host_mode_i ##1 !bus_i.wr ##1 rd_st; endsequence
    sequence wes_s; $rose(wake_en_i) && !host_mode_i ##1 !bus_i.wr ##1 rd_st; endsequence
    sequence wsc_s; $fell(wake_status_i) && !host_mode_i ##1 !bus_i.wr ##1 rd_st; endsequence
    sequence clr_s; bus_i.wr && bus_i.addr == ptsf_pkg::STATUS_OFS && bus_i.wdata[24]
        && !pstate_wr_i ##1 rd_st && !pstate_wr_i; endsequence
    a_rsvd_zero: assert property (bus_i.rd |=> rdata_o[31:25] == 7'h0 &&
        rdata_o[16:0] == 17'h0) else $error("reserved bits not zero");
    a_m66_live: assert property (rd_st && $stable(m66en_i) && !$past(rst_i)
        |=> rdata_o[21] == $past(m66en_i)) else $error("m66 bit wrong");
    a_empty_live: assert property (rd_st && $stable(empty_i) && !$past(rst_i)
        |=> rdata_o[20:17] == $past(empty_i)) else $error("empty bits wrong");
    a_psc_set: assert property (psc_s |=> rdata_o[24]) else $error("psc not set");
    a_wes_set: assert property (wes_s |=> rdata_o[23]) else $error("wes not set");
    a_wsc_set: assert property (wsc_s |=> rdata_o[22]) else $error("wsc not set");
    a_w1c_clear: assert property (clr_s |=> !rdata_o[24]) else $error("flag kept");
    a_mask_off: assert property (bus_i.wr && bus_i.addr == ptsf_pkg::MASK_OFS &&
        bus_i.wdata[24:21] == 4'h0 |=> ##1 !irq_o) else $error("irq stays high");
endmodule
bind ptsf_top ptsf_top_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .pstate_wr_i(pstate_wr_i), .wake_en_i(wake_en_i),
    .wake_status_i(wake_status_i), .host_mode_i(host_mode_i), .m66en_i(m66en_i),
    .empty_i(empty_i), .irq_o(irq_o));
`default_nettype wire

// ===== sim/tb_top.sv
// tb_top: self-checking bench for ptsf_top with a host model.
// assumes the design's pins and register port as in ptsf_pkg.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [1:0] ev; logic m66; logic [3:0] emp; logic [2:0] flg;} ptsf_row_s;
    localparam logic [15:0] ST = ptsf_pkg::STATUS_OFS;
    localparam logic [15:0] MK = ptsf_pkg::MASK_OFS;
    ptsf_row_s rows [4] = '{'{2'h1, 1'b1, 4'h8, 3'h4}, '{2'h2, 1'b0, 4'h4, 3'h2},
                            '{2'h3, 1'b1, 4'h2, 3'h1}, '{2'h0, 1'b0, 4'h1, 3'h0}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic host = 1'b0;
    logic m66 = 1'b0;
    logic [3:0] emp = 4'hf;
    logic pw, we, ws, irq;
    logic [31:0] rdata, q;
    ptsf_pkg::ptsf_bus_req_s bus = '0;
    int errors = 0;
    int n_tests = 0;
    always #5 clk_i = ~clk_i;
    ptsf_host_model i_host (.clk_i(clk_i), .pstate_wr_o(pw), .wake_en_o(we), .wake_status_o(ws));
    ptsf_top i_ptsf_top (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
        .pstate_wr_i(pw), .wake_en_i(we), .wake_status_i(ws), .host_mode_i(host),
        .m66en_i(m66), .empty_i(ptsf_pkg::ptsf_empty_s'(emp)), .irq_o(irq));
    // optional write, then a read of the same address in the next cycle
    task automatic op(input bit w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        if (w) begin
            bus <= '{a, d, 1'b1, 1'b0};
            @(posedge clk_i);
        end
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 q = rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e);
        chk(n, {31'h0, e}, {31'h0, irq});
    endtask
    task automatic pins(input logic m, input logic [3:0] e);
        @(posedge clk_i);
        m66 <= m;
        emp <= e;
    endtask
    task automatic report_and_stop();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        op(1'b0, ST, 32'h0); chk("reset", 32'h001e0000, q);
        for (int i = 0; i < 4; i++) begin
            pins(rows[i].m66, rows[i].emp);
            i_host.pm_write(rows[i].ev);
            op(1'b0, ST, 32'h0);
            chk("status", {7'h0, rows[i].flg, rows[i].m66, rows[i].emp, 17'h0}, q);
            op(1'b1, ST, 32'hffffffff);
            chk("cleared", {10'h0, rows[i].m66, rows[i].emp, 17'h0}, q);
        end
        i_host.pm_write(2'h1);
        op(1'b1, ST, 32'h0); chk("kept", 32'h01020000, q);
        op(1'b1, MK, 32'h01200000); chk("mask", 32'h01200000, q);
        chk_bit("irq flag", 1'b1);
        op(1'b1, ST, 32'h01000000); chk_bit("irq cleared", 1'b0);
        pins(1'b1, 4'h1);
        op(1'b1, ST, 32'h00200000); chk("m66 kept", 32'h00220000, q);
        chk_bit("irq m66", 1'b1);
        op(1'b1, MK, 32'h0); chk_bit("irq masked", 1'b0);
        @(posedge clk_i);
        host <= 1'b1;
        i_host.pm_write(2'h1);
        i_host.pm_write(2'h3);
        @(posedge clk_i);
        host <= 1'b0;
        op(1'b0, ST, 32'h0); chk("host mode", 32'h00220000, q);
        op(1'b1, 16'hd09c, 32'hffffffff); chk("unmapped", 32'h0, q);
        report_and_stop();
    end
endmodule
`default_nettype wire
